//--- rtl/aic_pkg.sv
// Package with register map, field positions, limits and codes of the analog input logic.
package aic_pkg;

   // Register byte offsets.
   localparam logic [7:0] AIC_CTRL     = 8'h00;
   localparam logic [7:0] AIC_WIN_HIGH = 8'h04;
   localparam logic [7:0] AIC_WIN_LOW  = 8'h08;
   localparam logic [7:0] AIC_WIN_HYS  = 8'h0c;
   localparam logic [7:0] AIC_THR1     = 8'h10;
   localparam logic [7:0] AIC_HYS1     = 8'h14;
   localparam logic [7:0] AIC_THR2     = 8'h18;
   localparam logic [7:0] AIC_HYS2     = 8'h1c;
   localparam logic [7:0] AIC_ILIM_MIN = 8'h20;
   localparam logic [7:0] AIC_ILIM_MAX = 8'h24;
   localparam logic [7:0] AIC_VLIM_MAX = 8'h28;
   localparam logic [7:0] AIC_SAT_LO   = 8'h2c;
   localparam logic [7:0] AIC_SAT_HI   = 8'h30;
   localparam logic [7:0] AIC_STATUS   = 8'h34;
   localparam logic [7:0] AIC_MEAS     = 8'h38;

   // Control register field positions.
   localparam int AIC_C_WIN_EN   = 0;
   localparam int AIC_C_THR1_EN  = 1;
   localparam int AIC_C_THR2_EN  = 2;
   localparam int AIC_C_ZERO_RNG = 3;
   localparam int AIC_C_VOLT     = 4;
   localparam int AIC_C_SAT25    = 5;
   localparam int AIC_C_ERR_EN   = 6;
   localparam int AIC_C_RATE_LSB = 8;
   localparam int AIC_RATE_W     = 4;

   // Status register field positions.
   localparam int AIC_S_FIRST_COMPARATOR_OUTPUT  = 0;
   localparam int AIC_S_SECOND_COMPARATOR_OUTPUT  = 1;
   localparam int AIC_S_WIN   = 2;
   localparam int AIC_S_THR1  = 3;
   localparam int AIC_S_THR2  = 4;
   localparam int AIC_S_DIAG  = 5;
   localparam int AIC_S_ANOM  = 6;
   localparam int AIC_S_ERR   = 7;

   // Sample rate codes: 2.5,5,10,16.6,20,50,60,100,200,400,800,1000,2000,4000 sps.
   localparam logic [3:0] AIC_RATE_LAST  = 4'hd;
   localparam logic [3:0] AIC_RATE_RESET = 4'h7;

   // Electrical limits; current in microamps, voltage in millivolts.
   localparam logic [15:0] AIC_IMIN_LO  = 16'd2500;
   localparam logic [15:0] AIC_IMIN_HI  = 16'd3900;
   localparam logic [15:0] AIC_IMAX_LO  = 16'd20100;
   localparam logic [15:0] AIC_IMAX_HI  = 16'd23000;
   localparam logic [15:0] AIC_VMAX_LO  = 16'd10050;
   localparam logic [15:0] AIC_VMAX_HI  = 16'd11500;
   localparam logic [15:0] AIC_IMIN_RST = 16'd3100;
   localparam logic [15:0] AIC_IMAX_RST = 16'd21000;
   localparam logic [15:0] AIC_VMAX_RST = 16'd11000;

   // Forced electrical readings during a sensor anomaly.
   localparam logic [15:0] AIC_SAT_0MA  = 16'd0;
   localparam logic [15:0] AIC_SAT_25MA = 16'd25000;

   // Window comparator states.
   typedef enum logic {AIC_OUT_WIN, AIC_IN_WIN} aic_win_t;

endpackage : aic_pkg

//--- rtl/aic_channel.sv
// Post-conversion comparators, range diagnosis and anomaly handling of one analog channel.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Window output is 0 out of window, 1 in window.
// - Enabled window comparator drives first output; thresholds in engineering units.
// - Out of window when above high or below low minus hysteresis.
// - In window stays while below high and above low minus hysteresis.
// - Out of window stays at or above high-hys or at or below low.
// - Enter window only when below high-hys and above low.
// - Two independent, separately enabled threshold comparators; threshold 1 drives the first output only while the window is disabled.
// - Threshold output is 1 over threshold, 0 under threshold.
// - Over when above threshold; held while above threshold minus hysteresis.
// - Under when below threshold minus hysteresis; held while below threshold.
// - Sample rate selectable among fourteen rates, 2.5 to 4000 per second.
// - Current diagnosis when below minimum or above maximum current.
// - Minimum current 2.5 to 3.9 mA, maximum 20.1 to 23 mA.
// - Voltage: only maximum, 10.05 to 11.5 V; diagnosis above it.
// - On anomaly force measurement to selected 0 mA or 25 mA value.
// - Anomalies: cable break (4-20 mA only), supply overload, input overload.
// - Zero-based current range skips cable and minimum-current checks.
// - Enabled error output is 1 during anomaly, else 0.
module aic_channel
   import aic_pkg::*;
(
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Register port.
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // Converter results.
   input  wire logic                  sample_valid,
   input  wire logic signed [31:0]    sample_eng,
   input  wire logic [15:0]           sample_raw,
   // Sensor anomaly indications.
   input  wire logic                  cable_open,
   input  wire logic                  supply_overload,
   input  wire logic                  input_overload,
   // Converter configuration.
   output logic [aic_pkg::AIC_RATE_W-1:0] conv_rate_sel,
   // Results toward the controller logic.
   output logic                       first_comparator_output,
   output logic                       second_comparator_output,
   output logic                       range_diag,
   output logic                       error_out,
   output logic signed [31:0]         meas_out,
   output logic                       meas_valid
);
   import aic_pkg::*;

   // Configuration registers.
   logic [31:0]        ctrl;
   logic signed [31:0] win_high;
   logic signed [31:0] win_low;
   logic signed [31:0] win_hys;
   logic signed [31:0] thr1;
   logic signed [31:0] hys1;
   logic signed [31:0] thr2;
   logic signed [31:0] hys2;
   logic [15:0]        ilim_min;
   logic [15:0]        ilim_max;
   logic [15:0]        vlim_max;
   logic signed [31:0] sat_lo;
   logic signed [31:0] sat_hi;

   // Comparator and diagnosis state.
   aic_win_t           win_state;
   logic               thr1_over;
   logic               thr2_over;
   logic               anomaly;

   // Clamp a written limit into its legal span; software cannot set an illegal limit.
   // Clamping beats refusing: a bad write never leaves a stale limit.
   // Readback shows the clamped value that is really applied.
   function automatic logic [15:0] clamp_lim(input logic [15:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // Hysteresis threshold comparator step, shared by both threshold comparators.
   // Strict compares form the band: a reading equal to either edge
   // never moves the state.
   function automatic logic thr_step(input logic               over,
                                     input logic signed [32:0] m,
                                     input logic signed [32:0] t,
                                     input logic signed [32:0] h);
      logic r;
      r = over;
      if (!over && m > t) begin
         r = 1'b1;
      end else if (over && m < t - h) begin
         r = 1'b0;
      end
      return r;
   endfunction

   // Control field decode.
   // Bit 7 is stored without function.
   // Bits above the rate field are not stored and read as zero.
   wire win_en   = ctrl[AIC_C_WIN_EN];
   wire thr1_en  = ctrl[AIC_C_THR1_EN];
   wire thr2_en  = ctrl[AIC_C_THR2_EN];
   wire zero_rng = ctrl[AIC_C_ZERO_RNG];
   wire volt     = ctrl[AIC_C_VOLT];
   wire sat25    = ctrl[AIC_C_SAT25];
   wire err_en   = ctrl[AIC_C_ERR_EN];
   wire [AIC_RATE_W-1:0] wr_rate = reg_wdata[AIC_C_RATE_LSB +: AIC_RATE_W];
   wire rate_ok  = wr_rate <= AIC_RATE_LAST;

   // Anomaly detection; cable break only counts for a live-zero current sensor.
   // Without a live zero an open cable looks like a zero reading,
   // so the check would raise false anomalies there.
   wire cable_chk = !volt && !zero_rng;
   wire anom_now  = (cable_open && cable_chk) || supply_overload || input_overload;

   // Effective readings after saturation forcing.
   // The electrical reading is forced too, so a 25 mA anomaly, or a 0 mA one
   // in the live-zero current range, also shows in the range diagnosis.
   wire [15:0] raw_eff = anom_now ? (sat25 ? AIC_SAT_25MA : AIC_SAT_0MA) : sample_raw;
   wire signed [31:0] eng_eff = anom_now ? (sat25 ? sat_hi : sat_lo) : sample_eng;

   // Range diagnosis from the electrical reading.
   // Limits compare strictly: a reading equal to a limit is legal.
   // Voltage mode ignores the current limits entirely.
   wire below_min = !zero_rng && (raw_eff < ilim_min);
   wire diag_i    = below_min || (raw_eff > ilim_max);
   wire diag_v    = raw_eff > vlim_max;
   wire diag_now  = volt ? diag_v : diag_i;

   // Widened operands keep threshold minus hysteresis free of overflow.
   // A 33-bit difference of two 32-bit values cannot wrap, so a large
   // hysteresis never turns a low threshold into a high one.
   wire signed [32:0] m_w   = {eng_eff[31], eng_eff};
   wire signed [32:0] hi_w  = {win_high[31], win_high};
   wire signed [32:0] lo_w  = {win_low[31], win_low};
   wire signed [32:0] wh_w  = {win_hys[31], win_hys};
   wire signed [32:0] t1_w  = {thr1[31], thr1};
   wire signed [32:0] h1_w  = {hys1[31], hys1};
   wire signed [32:0] t2_w  = {thr2[31], thr2};
   wire signed [32:0] h2_w  = {hys2[31], hys2};

   // Window comparator decisions.
   // These wires may change freely between results; only a sample
   // edge lets them reach the state.
   wire leave_win = (m_w > hi_w) || (m_w < lo_w - wh_w);
   wire enter_win = (m_w < hi_w - wh_w) && (m_w > lo_w);
   aic_win_t next_win_state;
   always_comb begin
      next_win_state = win_state;
      case (win_state)
         AIC_IN_WIN: begin
            if (leave_win) begin
               next_win_state = AIC_OUT_WIN;
            end
         end
         AIC_OUT_WIN: begin
            if (enter_win) begin
               next_win_state = AIC_IN_WIN;
            end
         end
         default: next_win_state = AIC_OUT_WIN;
      endcase
   end

   // Threshold comparator next states.
   wire next_thr1_over = thr_step(thr1_over, m_w, t1_w, h1_w);
   wire next_thr2_over = thr_step(thr2_over, m_w, t2_w, h2_w);

   // Comparator outputs; window has first output when enabled.
   // Threshold 1 keeps tracking behind the window, so its result is
   // valid at once when the window is switched off.
   wire win_bit  = (win_state == AIC_IN_WIN);
   wire next_first_comparator_output = win_en ? win_bit : (thr1_en && thr1_over);
   wire next_second_comparator_output = thr2_en && thr2_over;

   // Register address decode.
   // Status and measurement offsets are read-only.
   // Writes to them fall into the default branch.
   wire wr_ctrl = reg_wr && (reg_addr == AIC_CTRL);

   // Control register; an illegal rate code leaves the previous rate in place.
   // Dropping the whole write would also lose the enables, which is
   // worse than keeping only the old rate.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= {20'h00000, AIC_RATE_RESET, 8'h00};
      end else if (wr_ctrl) begin
         ctrl[7:0] <= reg_wdata[7:0];
         if (rate_ok) begin
            ctrl[AIC_C_RATE_LSB +: AIC_RATE_W] <= wr_rate;
         end
      end
   end

   // Threshold and limit registers.
   // Hysteresis is not checked for sign; software must keep it
   // non-negative or the band turns inside out.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         win_high <= 32'sh0;
         win_low  <= 32'sh0;
         win_hys  <= 32'sh0;
         thr1     <= 32'sh0;
         hys1     <= 32'sh0;
         thr2     <= 32'sh0;
         hys2     <= 32'sh0;
         ilim_min <= AIC_IMIN_RST;
         ilim_max <= AIC_IMAX_RST;
         vlim_max <= AIC_VMAX_RST;
         sat_lo   <= 32'sh0;
         sat_hi   <= 32'sh0;
      end else if (reg_wr) begin
         case (reg_addr)
            AIC_WIN_HIGH: win_high <= reg_wdata;
            AIC_WIN_LOW:  win_low  <= reg_wdata;
            AIC_WIN_HYS:  win_hys  <= reg_wdata;
            AIC_THR1:     thr1     <= reg_wdata;
            AIC_HYS1:     hys1     <= reg_wdata;
            AIC_THR2:     thr2     <= reg_wdata;
            AIC_HYS2:     hys2     <= reg_wdata;
            AIC_ILIM_MIN: ilim_min <= clamp_lim(reg_wdata[15:0], AIC_IMIN_LO, AIC_IMIN_HI);
            AIC_ILIM_MAX: ilim_max <= clamp_lim(reg_wdata[15:0], AIC_IMAX_LO, AIC_IMAX_HI);
            AIC_VLIM_MAX: vlim_max <= clamp_lim(reg_wdata[15:0], AIC_VMAX_LO, AIC_VMAX_HI);
            AIC_SAT_LO:   sat_lo   <= reg_wdata;
            AIC_SAT_HI:   sat_hi   <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Comparator state steps only on a fresh converter result; a disabled one rests at 0.
   // Re-enabling a comparator therefore starts it from logic 0,
   // just as after reset.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         win_state <= AIC_OUT_WIN;
         thr1_over <= 1'b0;
         thr2_over <= 1'b0;
      end else if (sample_valid) begin
         win_state <= win_en ? next_win_state : AIC_OUT_WIN;
         thr1_over <= thr1_en && next_thr1_over;
         thr2_over <= thr2_en && next_thr2_over;
      end
   end

   // Outputs follow state; disabling a threshold comparator clears its output at once.
   // The extra register stage keeps the outputs free of glitches
   // toward the controller logic.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_comparator_output  <= 1'b0;
         second_comparator_output <= 1'b0;
      end else begin
         first_comparator_output  <= next_first_comparator_output;
         second_comparator_output <= next_second_comparator_output;
      end
   end

   // Diagnosis, anomaly and measurement per converter result.
   // The anomaly is captured with its own result, so it can never
   // run ahead of the forced measurement.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         range_diag <= 1'b0;
         anomaly    <= 1'b0;
         meas_out   <= 32'sh0;
      end else if (sample_valid) begin
         range_diag <= diag_now;
         anomaly    <= anom_now;
         meas_out   <= eng_eff;
      end
   end

   // Error flag and result strobe.
   // The enable gates the captured anomaly, so clearing it drops the
   // error output on the next edge without waiting for a sample.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         error_out  <= 1'b0;
         meas_valid <= 1'b0;
      end else begin
         error_out  <= err_en && anomaly;
         meas_valid <= sample_valid;
      end
   end

   assign conv_rate_sel = ctrl[AIC_C_RATE_LSB +: AIC_RATE_W];

   // Status word for software.
   // Bit 2 shows the window state, which rests at 0 while the window is disabled.
   // Bits above 7 read as zero.
   wire [31:0] status_word = {24'h000000, error_out, anomaly, range_diag, thr2_over,
                              thr1_over, win_bit, second_comparator_output,
                              first_comparator_output};

   // Read selection; unmapped offsets read zero.
   logic [31:0] rd_sel;
   always_comb begin
      case (reg_addr)
         AIC_CTRL:     rd_sel = ctrl;
         AIC_WIN_HIGH: rd_sel = win_high;
         AIC_WIN_LOW:  rd_sel = win_low;
         AIC_WIN_HYS:  rd_sel = win_hys;
         AIC_THR1:     rd_sel = thr1;
         AIC_HYS1:     rd_sel = hys1;
         AIC_THR2:     rd_sel = thr2;
         AIC_HYS2:     rd_sel = hys2;
         AIC_ILIM_MIN: rd_sel = {16'h0000, ilim_min};
         AIC_ILIM_MAX: rd_sel = {16'h0000, ilim_max};
         AIC_VLIM_MAX: rd_sel = {16'h0000, vlim_max};
         AIC_SAT_LO:   rd_sel = sat_lo;
         AIC_SAT_HI:   rd_sel = sat_hi;
         AIC_STATUS:   rd_sel = status_word;
         AIC_MEAS:     rd_sel = meas_out;
         default:      rd_sel = 32'h00000000;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   // Zero outside the answer cycle keeps an or-combined bus clean.
   // Reads have no side effects on any register.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_sel : 32'h00000000;
      end
   end

endmodule // aic_channel

`default_nettype wire

//--- test/aic_channel_monitor.sv
// Concurrent checks on the ports of the analog channel.
`timescale 1ns/1ps
`default_nettype none
module aic_channel_monitor
   import aic_pkg::*;
(
   // Clock and reset.
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // Register port.
   input wire logic [7:0]            reg_addr,
   input wire logic                  reg_wr,
   // Converter side.
   input wire logic                  sample_valid,
   input wire logic                  cable_open,
   input wire logic                  supply_overload,
   input wire logic                  input_overload,
   // Results.
   input wire logic [AIC_RATE_W-1:0] conv_rate_sel,
   input wire logic                  first_comparator_output,
   input wire logic                  second_comparator_output,
   input wire logic                  range_diag,
   input wire logic                  error_out,
   input wire logic signed [31:0]    meas_out,
   input wire logic                  meas_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // A control write may also move outputs through the enables.
   wire ctrl_wr = reg_wr && (reg_addr == AIC_CTRL);

   // Every result output but the rate code is tied to a converter result or a control write, so a spurious update shows at once.
   property p_mv; meas_valid == $past(sample_valid); endproperty
   a_mv: assert property (p_mv) else $error("meas_valid not one cycle after sample");
   property p_o1;
      $changed(first_comparator_output) |-> $past(sample_valid, 2) || $past(ctrl_wr, 2);
   endproperty
   a_o1: assert property (p_o1) else $error("first output moved without sample");
   property p_o2;
      $changed(second_comparator_output) |-> $past(sample_valid, 2) || $past(ctrl_wr, 2);
   endproperty
   a_o2: assert property (p_o2) else $error("second output moved without sample");
   property p_dg; $changed(range_diag) |-> $past(sample_valid); endproperty
   a_dg: assert property (p_dg) else $error("diagnosis moved without sample");
   property p_ms; !$past(sample_valid) |-> $stable(meas_out); endproperty
   a_ms: assert property (p_ms) else $error("measurement moved without sample");
   property p_ec;
      $changed(error_out) |-> $past(sample_valid, 2) || $past(ctrl_wr, 2);
   endproperty
   a_ec: assert property (p_ec) else $error("error output moved without sample");
   property p_er;
      $rose(error_out) |-> $past(cable_open | supply_overload | input_overload, 2);
   endproperty
   a_er: assert property (p_er) else $error("error output rose without anomaly");
   property p_rt; conv_rate_sel <= AIC_RATE_LAST; endproperty
   a_rt: assert property (p_rt) else $error("rate code out of list");
endmodule // aic_channel_monitor
`default_nettype wire

//--- test/aic_sensor_model.sv
// Behavioural sensor and converter feeding results to the channel.
`timescale 1ns/1ps
`default_nettype none
module aic_sensor_model (
   // Clock and reset.
   input wire logic                clk,
   input wire logic                sys_rst,
   // Commands from the bench.
   input wire logic                fire,
   input wire logic signed [31:0]  eng_in,
   input wire logic [15:0]         raw_in,
   input wire logic [2:0]          anom_in,
   // Converter results.
   output logic                    sample_valid,
   output logic signed [31:0]      sample_eng,
   output logic [15:0]             sample_raw,
   output logic                    cable_open,
   output logic                    supply_overload,
   output logic                    input_overload
);
   // Data toggle between results so a stale value is never mistaken for a fresh one.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sample_valid <= 1'b0;
         sample_eng <= 32'sh0;
         sample_raw <= 16'h0;
         {cable_open, supply_overload, input_overload} <= 3'h0;
      end else begin
         sample_valid <= fire;
         sample_eng <= fire ? eng_in : ~sample_eng;
         sample_raw <= fire ? raw_in : ~sample_raw;
         if (fire) begin
            {cable_open, supply_overload, input_overload} <= anom_in;
         end
      end
   end
endmodule // aic_sensor_model
`default_nettype wire

//--- test/aic_channel_tb_top.sv
// Self-checking bench for the analog channel post-conversion logic.
`timescale 1ns/1ps
`default_nettype none
module aic_channel_tb_top;
   import aic_pkg::*;
   typedef struct packed {logic signed [31:0] eng; logic [15:0] raw; logic [2:0] exp;} aic_row_t;
   logic               clk = 1'b0;
   logic               sys_rst = 1'b1;
   logic [7:0]         reg_addr = 8'h0;
   logic [31:0]        reg_wdata = 32'h0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic               fire = 1'b0;
   logic signed [31:0] eng_in = 32'sh0;
   logic [15:0]        raw_in = 16'h0;
   logic [2:0]         anom_in = 3'h0;
   logic [31:0]        reg_rdata, d;
   logic signed [31:0] sample_eng, meas_out;
   logic [15:0]        sample_raw;
   logic [3:0]         conv_rate_sel;
   logic               sample_valid, cable_open, supply_overload, input_overload;
   logic               first_comparator_output, second_comparator_output;
   logic               range_diag, error_out, meas_valid;
   int                 fail_count = 0;
   int                 num_checks = 0;
   aic_row_t           rows [12];

   always #20 clk = ~clk;

   aic_sensor_model sen_u (.clk(clk), .sys_rst(sys_rst), .fire(fire), .eng_in(eng_in),
      .raw_in(raw_in), .anom_in(anom_in), .sample_valid(sample_valid),
      .sample_eng(sample_eng), .sample_raw(sample_raw), .cable_open(cable_open),
      .supply_overload(supply_overload), .input_overload(input_overload));
   aic_channel dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .sample_eng(sample_eng), .sample_raw(sample_raw), .cable_open(cable_open),
      .supply_overload(supply_overload), .input_overload(input_overload),
      .conv_rate_sel(conv_rate_sel), .first_comparator_output(first_comparator_output),
      .second_comparator_output(second_comparator_output), .range_diag(range_diag),
      .error_out(error_out), .meas_out(meas_out), .meas_valid(meas_valid));

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data is captured only in the single cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // One result; returns once comparator outputs and the error output have settled.
   task automatic smp(input logic signed [31:0] e, input logic [15:0] r, input logic [2:0] an);
      @(posedge clk);
      fire <= 1'b1;
      eng_in <= e;
      raw_in <= r;
      anom_in <= an;
      @(posedge clk);
      fire <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      // Window 20..100 with hysteresis 10, threshold 2 at 50 with hysteresis 5.
      rows = '{'{50, 3100, 3'b100}, '{95, 3099, 3'b111}, '{100, 21000, 3'b110},
         '{101, 21001, 3'b011}, '{90, 10000, 3'b010}, '{89, 10000, 3'b110},
         '{45, 10000, 3'b110}, '{44, 10000, 3'b100}, '{10, 10000, 3'b100},
         '{9, 10000, 3'b000}, '{20, 10000, 3'b000}, '{21, 10000, 3'b100}};
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk("rate", 32'h7, {28'h0, conv_rate_sel});
      chk("first_comparator_output", 32'h0, {31'h0, first_comparator_output});
      for (int i = 0; i < 15; i++) begin
         wr(AIC_CTRL, {20'h0, 4'(i), 8'h0});
         #1 chk("rate", (i > 13) ? 32'hd : 32'(i), {28'h0, conv_rate_sel});
      end
      wr(AIC_WIN_HIGH, 32'd100);
      wr(AIC_WIN_LOW, 32'd20);
      wr(AIC_WIN_HYS, 32'd10);
      wr(AIC_THR2, 32'd50);
      wr(AIC_HYS2, 32'd5);
      wr(AIC_CTRL, 32'h505);
      foreach (rows[i]) begin
         smp(rows[i].eng, rows[i].raw, 3'h0);
         chk("first_comparator_output", {31'h0, rows[i].exp[2]}, {31'h0, first_comparator_output});
         chk("second_comparator_output", {31'h0, rows[i].exp[1]}, {31'h0, second_comparator_output});
         chk("diag", {31'h0, rows[i].exp[0]}, {31'h0, range_diag});
         chk("meas", rows[i].eng, meas_out);
      end
      rd(AIC_ILIM_MIN, d);
      chk("imin", 32'd3100, d);
      wr(AIC_ILIM_MIN, 32'd1000);
      rd(AIC_ILIM_MIN, d);
      chk("imin", 32'd2500, d);
      rd(8'hfc, d);
      chk("unmapped", 32'h0, d);
      wr(AIC_VLIM_MAX, 32'd20000);
      rd(AIC_VLIM_MAX, d);
      chk("vmax", 32'd11500, d);
      wr(AIC_SAT_HI, 32'd777);
      wr(AIC_SAT_LO, 32'hfffffffb);
      wr(AIC_CTRL, 32'h565);
      smp(0, 10000, 3'b010);
      chk("meas", 32'd777, meas_out);
      chk("err", 32'h1, {31'h0, error_out});
      chk("diag", 32'h1, {31'h0, range_diag});
      wr(AIC_CTRL, 32'h545);
      smp(0, 10000, 3'b001);
      chk("meas", 32'hfffffffb, meas_out);
      chk("diag", 32'h1, {31'h0, range_diag});
      smp(0, 10000, 3'b100);
      chk("err", 32'h1, {31'h0, error_out});
      smp(60, 10000, 3'b000);
      chk("err", 32'h0, {31'h0, error_out});
      // Zero-based range ignores an open cable and the minimum limit.
      wr(AIC_CTRL, 32'h54d);
      smp(33, 0, 3'b100);
      chk("meas", 32'd33, meas_out);
      chk("diag", 32'h0, {31'h0, range_diag});
      chk("err", 32'h0, {31'h0, error_out});
      wr(AIC_CTRL, 32'h555);
      smp(101, 11501, 3'b000);
      chk("diag", 32'h1, {31'h0, range_diag});
      smp(101, 11500, 3'b000);
      chk("diag", 32'h0, {31'h0, range_diag});
      smp(101, 0, 3'b000);
      chk("diag", 32'h0, {31'h0, range_diag});
      wr(AIC_THR1, 32'd0);
      wr(AIC_HYS1, 32'd0);
      wr(AIC_CTRL, 32'h502);
      smp(1, 10000, 3'b000);
      chk("first_comparator_output", 32'h1, {31'h0, first_comparator_output});
      chk("second_comparator_output", 32'h0, {31'h0, second_comparator_output});
      rd(AIC_STATUS, d);
      chk("status", 32'h9, d);
      // The result strobe stands for one cycle, two edges after the request.
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      #1 chk("mvalid", 32'h1, {31'h0, meas_valid});
      @(posedge clk);
      #1 chk("mvalid", 32'h0, {31'h0, meas_valid});
      conclude();
   end
endmodule // aic_channel_tb_top

bind aic_channel aic_channel_monitor mon_u (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr),
   .sample_valid(sample_valid), .cable_open(cable_open), .supply_overload(supply_overload),
   .input_overload(input_overload), .conv_rate_sel(conv_rate_sel),
   .first_comparator_output(first_comparator_output),
   .second_comparator_output(second_comparator_output), .range_diag(range_diag),
   .error_out(error_out), .meas_out(meas_out), .meas_valid(meas_valid));
`default_nettype wire
